// ==== fqs_flash_ctrl.sv ====
// Our own choices: register access over APB and the placing of the registers.
module fqs_flash_ctrl
    import fqs_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE  = 16'h00A5, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5A01, // arbitrary value
    parameter int          PULSE_CYC   = FQS_PULSE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        seq_busy,
    input  wire logic        seq_suspended,
    input  wire logic        prog_done,
    input  wire logic        erase_done,
    input  wire logic [15:0] array_data,
    output logic      [15:0] array_addr,
    output logic             prog_req,
    output logic             erase_req,
    output logic             completion_status_pin,
    output logic             irq
);

    // ****************************************************
    // bus decode
    // ****************************************************
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        wr_acc;
    logic        rd_setup;

    // a write acts only at the completing access edge
    assign wr_acc   = psel && penable && pwrite && pready_q;
    assign rd_setup = psel && !penable && !pwrite;

    // every register is one aligned word up to the last offset;
    // anything else answers with an error and changes nothing
    function automatic logic fqs_mapped(input logic [7:0] a);
        fqs_mapped = (a[1:0] == 2'h0) && (a <= FQS_PINCFG_OFS);
    endfunction

    // exact offset match, shared by all write strobes
    function automatic logic fqs_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
        fqs_hit = (a == ofs);
    endfunction

    // one-cycle write strobes, one per writable register
    logic cmd_wr;
    logic clr_wr;
    logic en_wr;
    logic addr_wr;

    assign cmd_wr  = wr_acc && fqs_hit(paddr, FQS_CMD_OFS);
    assign clr_wr  = wr_acc && fqs_hit(paddr, FQS_IRQ_CLR_OFS);
    assign en_wr   = wr_acc && fqs_hit(paddr, FQS_IRQ_EN_OFS);
    assign addr_wr = wr_acc && fqs_hit(paddr, FQS_ADDR_OFS);

    // ****************************************************
    // command interpreter
    // ****************************************************
    fqs_state_t    state_q;
    fqs_pin_mode_t pin_mode_q;
    logic [7:0]    cmd;
    logic          idle;
    logic          read_state;
    logic          cfg_bad;
    logic          seq_bad;
    logic          clr_status;

    // the command byte rides in the low byte lane of a write
    assign cmd        = pwdata[7:0];
    assign idle       = !seq_busy && !seq_suspended;
    assign read_state = (state_q == FQS_ST_ARRAY)  ||
                        (state_q == FQS_ST_STATUS) ||
                        (state_q == FQS_ST_CONFIG) ||
                        (state_q == FQS_ST_QUERY);
    // reserved bits of the pin code must be zero
    assign cfg_bad    = cmd_wr && (state_q == FQS_ST_PIN_CFG) &&
                        (cmd[7:2] != 6'h00);
    // erase setup accepts only the confirm code
    assign seq_bad    = cmd_wr && (state_q == FQS_ST_ERASE) &&
                        (cmd != FQS_CMD_CONFIRM);
    assign clr_status = cmd_wr && read_state &&
                        (cmd == FQS_CMD_CLR_STAT);

    // next state on each command cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= FQS_ST_ARRAY;
        end else if (cmd_wr) begin
            case (state_q)
                FQS_ST_ARRAY, FQS_ST_STATUS,
                FQS_ST_CONFIG, FQS_ST_QUERY: begin
                    case (cmd)
                        FQS_CMD_READ_ARRAY: state_q <= FQS_ST_ARRAY;
                        FQS_CMD_PROG_A,
                        FQS_CMD_PROG_B:     state_q <= FQS_ST_PROG;
                        FQS_CMD_BUF_WRITE:  state_q <= FQS_ST_BUF;
                        FQS_CMD_BFP:        state_q <= FQS_ST_BFP;
                        FQS_CMD_ERASE:      state_q <= FQS_ST_ERASE;
                        FQS_CMD_READ_STAT:  state_q <= FQS_ST_STATUS;
                        FQS_CMD_READ_ID:    state_q <= FQS_ST_CONFIG;
                        FQS_CMD_QUERY:      state_q <= FQS_ST_QUERY;
                        FQS_CMD_PIN_CFG:    state_q <= FQS_ST_PIN_CFG;
                        default:            state_q <= state_q;
                    endcase
                end
                // program and erase second cycles all leave status readable
                FQS_ST_PROG, FQS_ST_BUF, FQS_ST_BFP,
                FQS_ST_ERASE: state_q <= FQS_ST_STATUS;
                FQS_ST_PIN_CFG: state_q <= FQS_ST_ARRAY;
                default:        state_q <= FQS_ST_ARRAY;
            endcase
        end
    end

    // start requests to the sequencer, one cycle each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_req  <= 1'b0;
            erase_req <= 1'b0;
        end else begin
            prog_req  <= cmd_wr && ((state_q == FQS_ST_PROG) ||
                                    (state_q == FQS_ST_BUF)  ||
                                    (state_q == FQS_ST_BFP));
            erase_req <= cmd_wr && (state_q == FQS_ST_ERASE) &&
                         (cmd == FQS_CMD_CONFIRM);
        end
    end

    // pin mode: kept until reset or a valid new code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_mode_q <= FQS_PIN_LEVEL;
        end else if (cmd_wr && (state_q == FQS_ST_PIN_CFG) &&
                     !cfg_bad) begin
            // busy or suspended host is outside its contract
            pin_mode_q <= fqs_pin_mode_t'(cmd[1:0]);
        end
    end

    // ****************************************************
    // status error bits, set wins over clear
    // ****************************************************
    // only command errors are raised here; failures reported by
    // the sequencer itself are outside this block
    logic pe_q;
    logic ee_q;
    logic [7:0] sr;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_q <= FQS_SR_RESET[FQS_SR_PE_BIT];
            ee_q <= FQS_SR_RESET[FQS_SR_EE_BIT];
        end else if (cfg_bad || seq_bad) begin
            pe_q <= 1'b1;
            ee_q <= 1'b1;
        end else if (clr_status) begin
            pe_q <= 1'b0;
            ee_q <= 1'b0;
        end
    end

    // ready comes straight from the sequencer
    always_comb begin
        sr                   = 8'h00;
        sr[FQS_SR_READY_BIT] = !seq_busy;
        sr[FQS_SR_EE_BIT]    = ee_q;
        sr[FQS_SR_PE_BIT]    = pe_q;
    end

    // ****************************************************
    // completion status pin
    // ****************************************************
    // the counter covers the whole pulse; a host that needs a
    // longer low time must raise PULSE_CYC, not stretch events
    localparam int PW = $clog2(PULSE_CYC + 1);
    logic [PW-1:0] pulse_cnt_q;
    logic          pulse_fire;

    always_comb begin
        case (pin_mode_q)
            FQS_PIN_ERASE:      pulse_fire = erase_done;
            FQS_PIN_PROG:       pulse_fire = prog_done;
            FQS_PIN_ERASE_PROG: pulse_fire = erase_done ||
                                             prog_done;
            default:            pulse_fire = 1'b0;
        endcase
    end

    // a new event during a pulse restarts the width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_q <= '0;
        end else if (pulse_fire) begin
            pulse_cnt_q <= PW'(PULSE_CYC);
        end else if (pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - PW'(1);
        end
    end

    // level mode mirrors busy one cycle late; pulse modes go low
    // in the cycle after the done event, for the counted width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            completion_status_pin <= 1'b1;
        end else if (pin_mode_q == FQS_PIN_LEVEL) begin
            completion_status_pin <= !seq_busy;
        end else begin
            completion_status_pin <= !(pulse_fire ||
                                       (pulse_cnt_q > PW'(1)));
        end
    end

    // ****************************************************
    // interrupts
    // ****************************************************
    fqs_evt_t evt;
    fqs_evt_t irq_stat_q;
    fqs_evt_t irq_en_q;

    // event bits in the order of the status layout
    assign evt = '{seq_err: seq_bad, cfg_err: cfg_bad,
                   prog_done: prog_done, erase_done: erase_done};

    // an event in the clear cycle stays set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= evt | (irq_stat_q &
                          ~(clr_wr ? fqs_evt_t'(pwdata[3:0]) : '0));
        end
    end

    // enable register, always written as a whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= '0;
        end else if (en_wr) begin
            irq_en_q <= fqs_evt_t'(pwdata[3:0]);
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ****************************************************
    // read address and data
    // ****************************************************
    // word address shared by array, id and query reads
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            array_addr <= 16'h0000;
        end else if (addr_wr) begin
            array_addr <= pwdata[15:0];
        end
    end

    logic [15:0] data_word;

    // one word per read; no page or burst is offered
    always_comb begin
        case (state_q)
            FQS_ST_STATUS: data_word = {8'h00, sr};
            FQS_ST_CONFIG: begin
                case (array_addr[7:0])
                    8'h00:   data_word = MAKER_CODE;
                    8'h01:   data_word = DEVICE_CODE;
                    default: data_word = 16'h0000;
                endcase
            end
            FQS_ST_QUERY:
                data_word = fqs_query_word(array_addr[7:0]);
            default:       data_word = array_data;
        endcase
    end

    // register read mux, looked at only in the setup cycle
    logic [31:0] rd_mux;

    always_comb begin
        case (paddr)
            FQS_ADDR_OFS:     rd_mux = {16'h0000, array_addr};
            FQS_DATA_OFS:     rd_mux = {16'h0000, data_word};
            FQS_STATUS_OFS:   rd_mux = {24'h000000, sr};
            FQS_IRQ_STAT_OFS: rd_mux = {28'h0000000, irq_stat_q};
            FQS_IRQ_EN_OFS:   rd_mux = {28'h0000000, irq_en_q};
            FQS_PINCFG_OFS:   rd_mux = {24'h000000, state_q,
                                        2'h0, pin_mode_q};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // ****************************************************
    // apb answer: no wait state, registered
    // ****************************************************
    // the registered answer gives the read mux the setup cycle to settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !fqs_mapped(paddr);
            prdata_q  <= rd_setup ? rd_mux : 32'h00000000;
        end
    end

    // bus outputs come straight from the answer flops
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

endmodule

// ==== fqs_flash_ctrl_props.sv ====
module fqs_flash_ctrl_props
    import fqs_pkg::*;
#(
    parameter int PULSE_CYC = FQS_PULSE_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        seq_busy,
    input wire logic        prog_done,
    input wire logic        erase_done,
    input wire logic        prog_req,
    input wire logic        erase_req,
    input wire logic        completion_status_pin
);
    // ****************************************************
    // mirror of pin mode and pulse timer
    // ****************************************************
    logic [1:0] mode_q;
    logic       armed_q;
    int         cnt_q;
    logic       cmd_wr;
    logic       wr_confirm;
    logic       hit;
    assign cmd_wr = psel && penable && pready && pwrite &&
                    paddr == FQS_CMD_OFS;
    assign wr_confirm = cmd_wr && pwdata[7:0] == FQS_CMD_CONFIRM;
    assign hit = (mode_q[0] && erase_done) || (mode_q[1] && prog_done);
    // limitation: assumes the config command is only sent from a read state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 2'h0;
            armed_q <= 1'b0;
        end else if (cmd_wr) begin
            armed_q <= !armed_q && pwdata[7:0] == FQS_CMD_PIN_CFG;
            if (armed_q && pwdata[7:2] == 6'h00) mode_q <= pwdata[1:0];
        end
    end
    // a new event restarts the window, as the pin does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_q <= 0;
        else cnt_q <= hit ? PULSE_CYC : (cnt_q != 0 ? cnt_q - 1 : 0);
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held more than one cycle");
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_unmapped_err: assert property (psel && !penable &&
        (paddr > FQS_PINCFG_OFS || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("unmapped access not flagged");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    chk_level_follow: assert property ($past(mode_q) == 2'h0 |->
        completion_status_pin == !$past(seq_busy))
        else $error("level pin does not follow busy");
    chk_pulse_start: assert property (hit |=> !completion_status_pin)
        else $error("pulse not started by event");
    chk_pulse_width: assert property ($past(mode_q) != 2'h0 |->
        completion_status_pin == (cnt_q == 0))
        else $error("pulse width wrong");
    chk_req_one_cycle: assert property ((prog_req || erase_req) |=>
        !prog_req && !erase_req)
        else $error("request longer than one cycle");
    chk_erase_cause: assert property (erase_req |->
        $past(wr_confirm) || $past(wr_confirm, 2))
        else $error("erase request without confirm");
    cov_pulse: cover property (hit ##1 !completion_status_pin);
    cov_erase: cover property (erase_req);
    cov_slverr: cover property (pslverr);
endmodule

bind fqs_flash_ctrl fqs_flash_ctrl_props #(.PULSE_CYC(PULSE_CYC)) u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .seq_busy(seq_busy),
    .prog_done(prog_done), .erase_done(erase_done), .prog_req(prog_req),
    .erase_req(erase_req), .completion_status_pin(completion_status_pin)
);

// ==== fqs_flash_ctrl_tb.sv ====
module fqs_flash_ctrl_tb
    import fqs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic        seq_busy, seq_susp, prog_done, erase_done;
    logic        prog_req, erase_req, pin, irq;
    logic [7:0]  paddr, busy_len;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] array_data, array_addr;
    logic [7:0]  pcmd [4] = '{8'h10, 8'h40, 8'hE8, 8'h30};
    int          fail_count, samples_checked, bl;
    fqs_flash_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .seq_busy(seq_busy), .seq_suspended(seq_susp), .prog_done(prog_done),
        .erase_done(erase_done), .array_data(array_data),
        .array_addr(array_addr), .prog_req(prog_req), .erase_req(erase_req),
        .completion_status_pin(pin), .irq(irq));
    fqs_seq_model u_seq (.pclk(pclk), .presetn(presetn), .prog_req(prog_req),
        .erase_req(erase_req), .array_addr(array_addr), .busy_len(busy_len),
        .seq_busy(seq_busy), .seq_suspended(seq_susp), .prog_done(prog_done),
        .erase_done(erase_done), .array_data(array_data));
    // ****************************************************
    // clock, tasks and expectations
    // ****************************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH at %0t got %h expected %h", $time, g, x);
        end
    endtask
    // one transfer; the idle edge first keeps drives one per time step
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
    endtask
    function automatic logic [31:0] qry(input logic [7:0] a);
        case (a)
            8'h10: return 32'h51;
            8'h11: return 32'h52;
            8'h12: return 32'h59;
            8'h13: return 32'h1;
            8'h27: return 32'h18;
            default: return 32'h0;
        endcase
    endfunction
    function automatic int lows(input logic [1:0] m, input bit er);
        if (m == 2'h0) return bl;
        return (er ? m[0] : m[1]) ? FQS_PULSE_CYC : 0;
    endfunction
    // run one operation and count the cycles the pin spends low
    task automatic op(input bit er, output int lo);
        bl = $urandom_range(40, 3);
        busy_len <= 8'(bl);
        apb(1'b1, FQS_CMD_OFS, er ? FQS_CMD_ERASE : pcmd[$urandom % 4]);
        apb(1'b1, FQS_CMD_OFS, er ? 32'hD0 : ($urandom & 32'hFF00));
        lo = 0;
        repeat (120) begin
            @(posedge pclk);
            if (pin !== 1'b1) lo++;
        end
    endtask
    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        logic [15:0] a;
        int          lo;
        fail_count = 0;
        samples_checked = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        busy_len = 8'h05;
        void'($urandom(32'h877A));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FQS_STATUS_OFS, 0);
        chk(r, 32'h80);
        apb(1'b0, FQS_PINCFG_OFS, 0);
        chk(r & 32'h3, 32'h0);
        $display("reset test done");
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_QUERY);
        for (int i = 0; i < 6; i++) begin
            a = i < 5 ? 16'(qry(8'h10 + 8'(i)) == 0 ? 8'h27 : 8'h10 + i) :
                16'($urandom % 256);
            apb(1'b1, FQS_ADDR_OFS, a);
            apb(1'b0, FQS_DATA_OFS, 0);
            chk(r, qry(a[7:0]));
        end
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_READ_ARRAY);
        a = 16'($urandom);
        apb(1'b1, FQS_ADDR_OFS, a);
        apb(1'b0, FQS_DATA_OFS, 0);
        chk(r, {16'h0, a[7:0], ~a[15:8]});
        $display("query and array test done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, FQS_CMD_OFS, FQS_CMD_PIN_CFG);
            apb(1'b1, FQS_CMD_OFS, m);
            apb(1'b0, FQS_PINCFG_OFS, 0);
            chk(r & 32'h3, m);
            op(1'b0, lo);
            chk(lo, lows(2'(m), 1'b0));
            op(1'b1, lo);
            chk(lo, lows(2'(m), 1'b1));
            $display("pin mode %0d test done", m);
        end
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_PIN_CFG);
        apb(1'b1, FQS_CMD_OFS, 32'h4 | ($urandom & 32'hFC));
        apb(1'b0, FQS_STATUS_OFS, 0);
        chk(r, 32'hB0);
        apb(1'b0, FQS_PINCFG_OFS, 0);
        chk(r & 32'h3, 32'h3);
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_CLR_STAT);
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_ERASE);
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_READ_ARRAY);
        apb(1'b0, FQS_STATUS_OFS, 0);
        chk(r, 32'hB0);
        apb(1'b1, FQS_CMD_OFS, FQS_CMD_CLR_STAT);
        apb(1'b0, FQS_STATUS_OFS, 0);
        chk(r, 32'h80);
        $display("error test done");
        apb(1'b0, FQS_IRQ_STAT_OFS, 0);
        chk(r, 32'hF);
        chk(irq, 1'b0);
        apb(1'b1, FQS_IRQ_EN_OFS, 1);
        apb(1'b0, FQS_IRQ_EN_OFS, 0);
        chk(irq, 1'b1);
        apb(1'b1, FQS_IRQ_CLR_OFS, 32'hF);
        apb(1'b0, FQS_IRQ_STAT_OFS, 0);
        chk(r, 32'h0);
        chk(irq, 1'b0);
        apb(1'b0, 8'h20, 0);
        chk(32'(e), 32'h1);
        chk(r, 32'h0);
        $display("interrupt and bus test done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, FQS_PINCFG_OFS, 0);
        chk(r & 32'h3, 32'h0);
        $display("second reset test done");
        summarize();
    end
endmodule

// ==== fqs_pkg.sv ====
package fqs_pkg;

    // ****************************************************
    // register map, byte addresses
    // ****************************************************
    localparam logic [7:0] FQS_CMD_OFS     = 8'h00;
    localparam logic [7:0] FQS_ADDR_OFS    = 8'h04;
    localparam logic [7:0] FQS_DATA_OFS    = 8'h08;
    localparam logic [7:0] FQS_STATUS_OFS  = 8'h0C;
    localparam logic [7:0] FQS_IRQ_STAT_OFS = 8'h10;
    localparam logic [7:0] FQS_IRQ_CLR_OFS = 8'h14;
    localparam logic [7:0] FQS_IRQ_EN_OFS  = 8'h18;
    localparam logic [7:0] FQS_PINCFG_OFS  = 8'h1C;

    // ****************************************************
    // command codes and field positions
    // ****************************************************
    localparam logic [7:0] FQS_CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] FQS_CMD_PROG_A     = 8'h10;
    localparam logic [7:0] FQS_CMD_PROG_B     = 8'h40;
    localparam logic [7:0] FQS_CMD_BUF_WRITE  = 8'hE8;
    localparam logic [7:0] FQS_CMD_BFP        = 8'h30;
    localparam logic [7:0] FQS_CMD_ERASE      = 8'h20;
    localparam logic [7:0] FQS_CMD_CONFIRM    = 8'hD0;
    localparam logic [7:0] FQS_CMD_READ_STAT  = 8'h70;
    localparam logic [7:0] FQS_CMD_CLR_STAT   = 8'h50;
    localparam logic [7:0] FQS_CMD_READ_ID    = 8'h90;
    localparam logic [7:0] FQS_CMD_QUERY      = 8'h98;
    localparam logic [7:0] FQS_CMD_PIN_CFG    = 8'hB8;
    localparam int FQS_SR_READY_BIT = 7;
    localparam int FQS_SR_EE_BIT    = 5;
    localparam int FQS_SR_PE_BIT    = 4;
    localparam logic [7:0] FQS_SR_RESET = 8'h80;

    // ****************************************************
    // status pin modes and timing
    // ****************************************************
    typedef enum logic [1:0] {
        FQS_PIN_LEVEL      = 2'h0,
        FQS_PIN_ERASE      = 2'h1,
        FQS_PIN_PROG       = 2'h2,
        FQS_PIN_ERASE_PROG = 2'h3
    } fqs_pin_mode_t;
    localparam int FQS_CLK_MHZ   = 200;
    localparam int FQS_PULSE_NS  = 250;
    localparam int FQS_PULSE_CYC = FQS_PULSE_NS * FQS_CLK_MHZ / 1000;

    // ****************************************************
    // command interpreter states, gray along read paths
    // ****************************************************
    typedef enum logic [3:0] {
        FQS_ST_ARRAY   = 4'h0,
        FQS_ST_STATUS  = 4'h1,
        FQS_ST_CONFIG  = 4'h3,
        FQS_ST_QUERY   = 4'h2,
        FQS_ST_PROG    = 4'h6,
        FQS_ST_BUF     = 4'h7,
        FQS_ST_BFP     = 4'h5,
        FQS_ST_ERASE   = 4'h4,
        FQS_ST_PIN_CFG = 4'hC
    } fqs_state_t;

    // interrupt events, one bit each
    typedef struct packed {
        logic seq_err;
        logic cfg_err;
        logic prog_done;
        logic erase_done;
    } fqs_evt_t;

    // query table: id string, command set, size exponent
    localparam logic [15:0] FQS_QRY_SIZE_LOG2 = 16'h0018;
    function automatic logic [15:0] fqs_query_word(input logic [7:0] a);
        case (a)
            8'h10:   fqs_query_word = 16'h0051;
            8'h11:   fqs_query_word = 16'h0052;
            8'h12:   fqs_query_word = 16'h0059;
            8'h13:   fqs_query_word = 16'h0001;
            8'h27:   fqs_query_word = FQS_QRY_SIZE_LOG2;
            default: fqs_query_word = 16'h0000;
        endcase
    endfunction

endpackage

// ==== fqs_seq_model.sv ====
module fqs_seq_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        prog_req,
    input  wire logic        erase_req,
    input  wire logic [15:0] array_addr,
    input  wire logic [7:0]  busy_len,
    output logic             seq_busy,
    output logic             seq_suspended,
    output logic             prog_done,
    output logic             erase_done,
    output logic      [15:0] array_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic       kind_q;
    // address pattern, so a wrong address shows in the data
    assign array_data = {array_addr[7:0], ~array_addr[15:8]};
    assign seq_suspended = 1'b0; // suspend is not modelled
    assign seq_busy = cnt_q != 8'h00;
    // one operation at a time; done pulses as busy drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            kind_q <= 1'b0;
            prog_done <= 1'b0;
            erase_done <= 1'b0;
        end else begin
            prog_done <= cnt_q == 8'h01 && !kind_q;
            erase_done <= cnt_q == 8'h01 && kind_q;
            if (prog_req || erase_req) begin
                cnt_q <= busy_len;
                kind_q <= erase_req;
            end else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule
